// *** logic/srs_supervisor.sv ***
// six-input reset supervisor: glitch filters, release timer, open-drain reset
// Functional notes
// RL1 - reset is driven low whenever any filtered input reports undervoltage.
// RL2 - reset stays low for the release delay after all inputs are good, releasing only if all are still good.
// RL3 - the release timer starts only once every input is good at the same time.
// RL4 - any input going bad while counting clears the timer, and a fresh full count starts when all are good again.
// RL5 - the delay applies only to release; a failing input asserts reset after the filter alone.
// RL6 - each undervoltage flag passes an integrating filter so only long enough transients act.
// RL7 - reset is asserted from reset onward and held until release conditions are met.
// RL8 - the pin is only ever driven low; when released it is left to the pull-up.
// RL9 - unused inputs are held good by the system so they never request reset.
// RL10 - the timer is a synchronous counter with a parameter terminal count, cleared on power-on reset.
`timescale 1ns/100ps
`default_nettype none
module srs_supervisor
  import srs_pkg::*;
#(
  parameter int unsigned RELEASE_COUNT = RELEASE_CYCLES,
  parameter int unsigned FILT_MAX      = FILT_DEPTH
) (
  input  wire logic    i_clk,
  input  wire logic    i_rst_n,
  input  wire srs_uv_t i_uv,
  output logic         o_rst_n_out,
  output logic         o_rst_n_oe_n,
  output logic         o_all_good
);
  localparam logic [FILT_WIDTH-1:0]  F_MAX  = FILT_WIDTH'(FILT_MAX);
  localparam logic [FILT_WIDTH-1:0]  F_ONE  = FILT_WIDTH'(1);
  localparam logic [TIMER_WIDTH-1:0] T_END  = TIMER_WIDTH'(RELEASE_COUNT - 1);

  logic [NUM_INPUTS-1:0] uv_raw;
  logic [FILT_WIDTH-1:0] filt_r   [NUM_INPUTS];
  logic [FILT_WIDTH-1:0] filt_nxt [NUM_INPUTS];
  logic [NUM_INPUTS-1:0] uv_r;
  logic [NUM_INPUTS-1:0] uv_nxt;
  srs_state_t            state_r;
  srs_state_t            state_nxt;
  logic [TIMER_WIDTH-1:0] timer_r;
  logic [TIMER_WIDTH-1:0] timer_nxt;
  logic                  oe_n_r;
  logic                  oe_n_nxt;
  logic                  any_uv;

  assign uv_raw = i_uv;

  // integrating filters with hysteresis on the integrator level
  always_comb begin
    for (int k = 0; k < NUM_INPUTS; k++) begin
      filt_nxt[k] = filt_r[k];
      uv_nxt[k]   = uv_r[k];
      if (uv_raw[k] && filt_r[k] != F_MAX) begin // [RL6]
        filt_nxt[k] = filt_r[k] + 1'b1;
      end else if (!uv_raw[k] && filt_r[k] != '0) begin // [RL6]
        filt_nxt[k] = filt_r[k] - 1'b1;
      end
      if (filt_nxt[k] == F_MAX) begin
        uv_nxt[k] = 1'b1;
      end else if (filt_nxt[k] == '0) begin
        uv_nxt[k] = 1'b0;
      end
    end
  end

  // filters start at full scale so inputs count as bad until proven good
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < NUM_INPUTS; k++) begin
        filt_r[k] <= F_MAX;
      end
      uv_r <= '1;
    end else begin
      filt_r <= filt_nxt;
      uv_r   <= uv_nxt;
    end
  end

  assign any_uv = |uv_r;

  // release timer and output state
  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    oe_n_nxt  = oe_n_r;
    if (any_uv) begin
      state_nxt = SRS_HOLD; // [RL1] [RL4] [RL5]
      timer_nxt = TIMER_RESET_VAL; // [RL4]
      oe_n_nxt  = 1'b0; // [RL1]
    end else begin
      unique case (state_r)
        SRS_HOLD: begin
          state_nxt = SRS_COUNT; // [RL3]
          timer_nxt = TIMER_RESET_VAL;
        end
        SRS_COUNT: begin
          if (timer_r >= T_END) begin
            state_nxt = SRS_RELEASED; // [RL2]
            oe_n_nxt  = 1'b1; // [RL8]
          end else begin
            timer_nxt = timer_r + 1'b1; // [RL10]
          end
        end
        SRS_RELEASED: begin
          oe_n_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= SRS_HOLD; // [RL7]
      timer_r <= TIMER_RESET_VAL; // [RL10]
      oe_n_r  <= 1'b0; // [RL7]
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      oe_n_r  <= oe_n_nxt;
    end
  end

  assign o_rst_n_oe_n = oe_n_r;
  assign o_all_good   = oe_n_r;
  // output data is always low; the pin is only ever pulled down
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rst_n_out <= 1'b0;
    end else begin
      o_rst_n_out <= 1'b0; // [RL8]
    end
  end

  sequence s_all_good_since_count;
    (state_r == SRS_COUNT) && !any_uv;
  endsequence

  sequence s_inputs_recover;
    $fell(any_uv) && (state_r == SRS_HOLD);
  endsequence

  sequence s_count_armed;
    (state_r == SRS_COUNT) && (timer_r == '0);
  endsequence

  sequence s_count_expired;
    (state_r == SRS_COUNT) && !any_uv && (timer_r == T_END);
  endsequence

  sequence s_line_released;
    (state_r == SRS_RELEASED) && o_rst_n_oe_n && o_all_good;
  endsequence

  AST_UV_ASSERTS: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL1]
    any_uv |=> !o_rst_n_oe_n)
    else $error("reset not asserted on undervoltage");
  AST_UV_CLEARS_TIMER: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL4]
    any_uv |=> timer_r == '0 && state_r == SRS_HOLD)
    else $error("timer not cleared on undervoltage");
  AST_START_ALL_GOOD: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL3]
    (state_r == SRS_HOLD && !any_uv) |=> state_r == SRS_COUNT && timer_r == '0)
    else $error("timer did not start when all inputs good");
  AST_COUNT_STEP: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL10]
    (s_all_good_since_count and (timer_r < T_END)) |=> timer_r == $past(timer_r) + 1'b1)
    else $error("timer did not advance");
  AST_NO_EARLY_RELEASE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL2]
    $rose(o_rst_n_oe_n) |-> $past(timer_r) == T_END && $past(state_r) == SRS_COUNT)
    else $error("release before full delay");
  AST_RELEASE_AT_END: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL2]
    (s_all_good_since_count and (timer_r == T_END)) |=> o_rst_n_oe_n)
    else $error("no release at end of delay");
  AST_ONLY_LOW: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL8]
    o_rst_n_out == 1'b0)
    else $error("reset pin driven high");
  AST_FILTER_SLOW: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL6]
    $rose(uv_r[0]) |-> $past(filt_r[0]) == F_MAX - 1'b1)
    else $error("flag changed before integrator full");
  AST_HELD_WHILE_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL7]
    (state_r != SRS_RELEASED) |-> !o_rst_n_oe_n)
    else $error("reset released outside released state");
  AST_FAST_ASSERT: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL5]
    $rose(any_uv) |=> state_r == SRS_HOLD)
    else $error("assertion waited on timer");

  // release path and timer checks
  AST_RECOVER_ARMS: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL3]
    s_inputs_recover |=> s_count_armed)
    else $error("timer not armed after inputs recovered");
  AST_EXPIRY_RELEASES: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL2]
    s_count_expired |=> s_line_released)
    else $error("line not released when delay expired");
  AST_RELEASE_ALL_GOOD: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL2]
    $rose(o_rst_n_oe_n) |-> !$past(any_uv))
    else $error("released while an input was bad");
  AST_RELEASED_HOLDS: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL2]
    ((state_r == SRS_RELEASED) && !any_uv) |=> s_line_released)
    else $error("release dropped while all inputs good");
  AST_HOLD_TIMER_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL4]
    (state_r == SRS_HOLD) |-> (timer_r == '0))
    else $error("timer not cleared while holding");
  AST_TIMER_BOUND: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL10]
    timer_r <= T_END)
    else $error("timer ran past terminal count");

  // per-input integrator checks, one set for every monitored input
  for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_filt_chk
    AST_FILT_BOUND: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL6]
      filt_r[g] <= F_MAX)
      else $error("integrator above full scale");
    AST_FILT_UP: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL6]
      (uv_raw[g] && (filt_r[g] != F_MAX)) |=> (filt_r[g] == $past(filt_r[g]) + 1'b1))
      else $error("integrator did not count up");
    AST_FILT_DOWN: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL6]
      (!uv_raw[g] && (filt_r[g] != '0)) |=> (filt_r[g] == $past(filt_r[g]) - 1'b1))
      else $error("integrator did not count down");
    AST_FLAG_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL6]
      $rose(uv_r[g]) |-> ($past(filt_r[g]) == F_MAX - 1'b1))
      else $error("flag set before integrator full");
    AST_FLAG_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL6]
      $fell(uv_r[g]) |-> ($past(filt_r[g]) == F_ONE))
      else $error("flag cleared before integrator empty");
  end : g_filt_chk
endmodule : srs_supervisor
`default_nettype wire

// *** shared/srs_pkg.sv ***
// constants and types of the six-input reset supervisor
package srs_pkg;
  localparam int unsigned NUM_INPUTS      = 6;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned RELEASE_MS      = 200;
  // release delay in clock cycles, rounded down (shortest time)
  localparam int unsigned RELEASE_CYCLES  = (RELEASE_MS * (CLK_HZ / 1000));
  localparam int unsigned FILT_WIDTH      = 8;
  localparam int unsigned FILT_DEPTH      = 64;
  localparam int unsigned FILT_RESET_VAL  = 0;
  localparam int unsigned TIMER_WIDTH     = 32;
  localparam logic [TIMER_WIDTH-1:0] TIMER_RESET_VAL = 32'h0000_0000;

  // undervoltage flags, one bit per monitored input, 1 = below threshold
  typedef struct packed {
    logic adjustable_in_2;
    logic adjustable_in_1;
    logic monitored_in_4;
    logic monitored_in_3;
    logic monitored_in_2;
    logic monitored_in_1;
  } srs_uv_t;

  typedef enum logic [1:0] {
    SRS_HOLD,
    SRS_COUNT,
    SRS_RELEASED
  } srs_state_t;
endpackage : srs_pkg

// *** testbench/srs_sys_model.sv ***
// system side model: pull-up on the shared reset line
`timescale 1ns/100ps
`default_nettype none
module srs_sys_model (
  input  wire logic i_rst_n_out,
  input  wire logic i_rst_n_oe_n,
  output logic      o_line_n
);
  // released line floats up to the weak pull-up, never a held value
  assign o_line_n = i_rst_n_oe_n ? 1'b1 : i_rst_n_out;
endmodule : srs_sys_model
`default_nettype wire

// *** testbench/srs_supervisor_tb.sv ***
// self-checking bench of the six-input reset supervisor
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %b seen %b", nm, e, g); end end
module srs_supervisor_tb;
  import srs_pkg::*;
  localparam int unsigned RC = 20;
  localparam int unsigned FM = 4;
  logic    i_clk      = 1'b0;
  logic    i_rst_n    = 1'b0;
  srs_uv_t i_uv       = '1;
  logic    out_n;
  logic    oe_n;
  logic    all_good;
  logic    line_n;
  int      n_mismatch = 0;
  int      n_checks   = 0;
  int      cyc        = 0;
  int      n;
  always #5 i_clk = ~i_clk;
  srs_supervisor #(.RELEASE_COUNT(RC), .FILT_MAX(FM)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_uv(i_uv),
    .o_rst_n_out(out_n), .o_rst_n_oe_n(oe_n), .o_all_good(all_good));
  srs_sys_model u_sys (.i_rst_n_out(out_n), .i_rst_n_oe_n(oe_n), .o_line_n(line_n));
  task automatic step(input int k);
    repeat (k) @(negedge i_clk);
  endtask : step
  // good inputs: counts edges until the line is released
  task automatic go_good();
    i_uv = '0;
    n = 0;
    while (line_n !== 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    `CHK("release_window", 1'b1, (n >= FM + RC && n <= FM + RC + 3))
    `CHK("all_good", 1'b1, all_good)
  endtask : go_good
  task automatic t_power();
    step(1);
    `CHK("line_in_reset", 1'b0, line_n)
    `CHK("drive_level", 1'b0, out_n)
    step(4);
    i_rst_n = 1'b1;
    go_good();
    i_rst_n = 1'b0;
    #1;
    `CHK("line_mid_reset", 1'b0, line_n)
    step(2);
    i_rst_n = 1'b1;
    go_good();
  endtask : t_power
  task automatic t_inputs();
    for (int b = 0; b < NUM_INPUTS; b++) begin
      i_uv = srs_uv_t'(6'h01 << b);
      step(FM + 2);
      `CHK("line_on_fail", 1'b0, line_n)
      `CHK("fast_assert", 1'b0, oe_n)
      `CHK("all_good_low", 1'b0, all_good)
      go_good();
    end
  endtask : t_inputs
  task automatic t_glitch();
    i_uv = 6'h01;
    step(FM - 1);
    i_uv = '0;
    step(10);
    `CHK("glitch_ignored", 1'b1, line_n)
    i_uv = 6'h02;
    step(FM);
    i_uv = '0;
    step(1);
    `CHK("long_glitch_acts", 1'b0, line_n)
    go_good();
  endtask : t_glitch
  task automatic t_restart();
    i_uv = 6'h20;
    step(FM + 2);
    i_uv = '0;
    step(FM + RC / 2);
    i_uv = 6'h20;
    step(FM + 2);
    `CHK("held_mid_count", 1'b0, line_n)
    `CHK("all_good_mid_count", 1'b0, all_good)
    go_good();
  endtask : t_restart
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    #1;
    t_power();
    t_inputs();
    t_glitch();
    t_restart();
    close_out();
  end
endmodule : srs_supervisor_tb
`default_nettype wire
